// *** common/rio_params.svh ***
// Overview of operation
// RL1: Respond after wait, gap, processing times.
// RL2: Outputs update within gap plus 4 ms.
// RL3: Configuration processing done within time plus 1 s.
// RL4: Master waits until configuration processing ends.
// RL5: Stop decelerates per stop action setting.
// RL6: Connection enable applies only after power cycle.
// RL7: Sixteen command bits map to net inputs.
// RL8: Forward bit on axis 0 runs continuously.
// RL9: Rate 625,000 bps, axis 0, switch off; code accepts any axis whose query address matches the control word.
// RL10: Serial error lights error indicator.
`ifndef RIO_PARAMS_SVH
`define RIO_PARAMS_SVH
// Byte offsets of the register words
`define RIO_OFS_CTRL 6'h00
`define RIO_OFS_QUERY 6'h04
`define RIO_OFS_NET_IN 6'h08
`define RIO_OFS_STATUS 6'h0c
`define RIO_OFS_IRQ_STAT 6'h10
`define RIO_OFS_IRQ_MASK 6'h14
`define RIO_OFS_CONN 6'h18
// Control word fields and reset values
`define RIO_CTRL_SW 0
`define RIO_CTRL_RATE_LO 4
`define RIO_CTRL_RATE_HI 7
`define RIO_CTRL_ADDR_LO 8
`define RIO_CTRL_ADDR_HI 12
`define RIO_CTRL_STOPACT 16
`define RIO_RATE_625K 4'h7
`define RIO_CTRL_RESET 32'h0000_0070
// Query word fields
`define RIO_Q_KIND_HI 3
`define RIO_Q_ADDR_LO 4
`define RIO_Q_ADDR_HI 8
`define RIO_Q_DATA_LO 16
// Net input bit positions
`define RIO_NI_SEL_HI 2
`define RIO_NI_STOP 5
`define RIO_NI_FREE 6
`define RIO_NI_DIR_LO 8
`define RIO_NI_DIR_HI 10
`define RIO_NI_FWD 14
`define RIO_NI_RVS 15
// Interrupt status bits
`define RIO_IRQ_RESP 0
`define RIO_IRQ_OUT 1
`define RIO_IRQ_CFG 2
`define RIO_IRQ_ERR 3
`define RIO_IRQ_REFUSE 4
`define RIO_IRQ_STOP 5
`define RIO_IRQ_W 6
// Times in their own units, clock period in ns
`define RIO_CLK_NS 4
`define RIO_TWAIT_NS 100000
`define RIO_GAP_NS 61600
`define RIO_PROC_NS 500000
`define RIO_CFG_PROC_NS 2000000
`define RIO_OUT_MAX_MS 4
`define RIO_CFG_MAX_MS 1000
`define RIO_DECEL_DIV_NS 1000
`endif

// *** common/rio_pkg.sv ***
`default_nettype none
package rio_pkg;
  // Query handler phases
  typedef enum logic [4:0] {
    RIO_IDLE = 5'h01,
    RIO_TWAIT = 5'h02,
    RIO_GAP = 5'h04,
    RIO_PROC = 5'h08,
    RIO_CFG = 5'h10
  } rio_state_t;
  // Query kinds
  typedef enum logic [3:0] {
    RIO_Q_START = 4'h1,
    RIO_Q_STOP = 4'h2,
    RIO_Q_SPEED = 4'h3,
    RIO_Q_ROUT = 4'h4,
    RIO_Q_CONFIG = 4'h5,
    RIO_Q_POLL = 4'h6
  } rio_kind_t;
endpackage
`default_nettype wire

// *** rtl/rio_top.sv ***
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rio_params.svh"
module rio_top import rio_pkg::*; #(
  parameter int TW_CYC = (`RIO_TWAIT_NS + `RIO_CLK_NS - 1) / `RIO_CLK_NS,
  parameter int GAP_CYC = (`RIO_GAP_NS + `RIO_CLK_NS - 1) / `RIO_CLK_NS,
  parameter int PROC_CYC = (`RIO_PROC_NS + `RIO_CLK_NS - 1) / `RIO_CLK_NS,
  parameter int CFG_CYC = (`RIO_CFG_PROC_NS + `RIO_CLK_NS - 1) / `RIO_CLK_NS,
  parameter int OUT_MAX_CYC = `RIO_OUT_MAX_MS * 1000000 / `RIO_CLK_NS,
  parameter int CFG_MAX_CYC = `RIO_CFG_MAX_MS * 1000000 / `RIO_CLK_NS,
  parameter int DECEL_DIV = `RIO_DECEL_DIV_NS / `RIO_CLK_NS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_error_pin,
  input wire logic nv_conn_enable,
  output logic irq,
  output logic resp_pulse,
  output logic [15:0] remote_out,
  output logic motor_run,
  output logic motor_dir,
  output logic motor_decel,
  output logic motor_free,
  output logic [2:0] op_select,
  output logic [2:0] direct_select,
  output logic serial_err_led,
  output logic cfg_busy,
  output logic conn_enable_active,
  output logic conn_enable_pending
);

  // Reset release and pin synchronisers
  logic rst_s1, rst_n_int;
  logic rxe_s1, rxe_s2, nv_s1, nv_s2;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n_int <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_int <= rst_s1;
    end
  end
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rxe_s1 <= 1'b0;
      rxe_s2 <= 1'b0;
      nv_s1 <= 1'b0;
      nv_s2 <= 1'b0;
    end else begin
      rxe_s1 <= rx_error_pin;
      rxe_s2 <= rxe_s1;
      nv_s1 <= nv_conn_enable;
      nv_s2 <= nv_s1;
    end
  end

  // Bus group state
  logic [31:0] ctrl, next_ctrl, net_in, next_net_in, next_readdata;
  logic [`RIO_IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic next_waitrequest, next_irq, next_conn_pending;
  logic [31:0] query, next_query, bemask;
  logic acc_rd, acc_wr, q_wr;
  // Query handler state
  rio_state_t state, next_state;
  logic [31:0] cnt, next_cnt, age, next_age;
  logic [15:0] speed, next_speed, next_remote_out;
  logic next_resp, next_err_led, out_upd, next_out_upd, cfg_done, next_cfg_done;
  logic q_ok, q_bad, q_refused, gap_end, do_start, do_stop;
  logic [`RIO_IRQ_W-1:0] ev;
  // Motion state
  logic next_run, next_dir, next_decel, next_free, cont_prev, next_cont_prev;
  logic [15:0] dcnt, next_dcnt;
  logic [31:0] div, next_div;
  logic tick, stopped, cont_fwd, cont_rvs, cont;
  logic [1:0] boot, next_boot;
  logic next_conn_active;

  // Requests take effect only at the edge where waitrequest is low
  assign acc_rd = avs_read & ~avs_waitrequest;
  assign acc_wr = avs_write & ~avs_waitrequest;
  assign q_wr = acc_wr && avs_address == `RIO_OFS_QUERY;
  assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Register slave: one wait cycle, then accept; read data set early
  always_comb begin
    next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
    next_readdata = avs_readdata;
    next_ctrl = ctrl;
    next_net_in = net_in;
    next_irq_mask = irq_mask;
    next_conn_pending = conn_enable_pending;
    next_query = query;
    next_irq_stat = irq_stat;
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `RIO_OFS_CTRL: next_readdata = ctrl;
        `RIO_OFS_QUERY: next_readdata = query;
        `RIO_OFS_NET_IN: next_readdata = net_in;
        `RIO_OFS_STATUS: next_readdata = {speed, 8'h00, 1'b0, conn_enable_active,
          serial_err_led, motor_decel, motor_dir, motor_run, cfg_busy, state != RIO_IDLE};
        `RIO_OFS_IRQ_STAT: next_readdata = {26'h0, irq_stat};
        `RIO_OFS_IRQ_MASK: next_readdata = {26'h0, irq_mask};
        `RIO_OFS_CONN: next_readdata = {31'h0, conn_enable_pending};
        default: next_readdata = 32'h0;
      endcase
    end
    if (acc_wr) begin
      case (avs_address)
        `RIO_OFS_CTRL: next_ctrl = (ctrl & ~bemask) | (avs_writedata & bemask);
        `RIO_OFS_QUERY: next_query = (query & ~bemask) | (avs_writedata & bemask);
        `RIO_OFS_NET_IN: next_net_in = ((net_in & ~bemask) | (avs_writedata & bemask))
          & 32'h0000_ffff;
        `RIO_OFS_IRQ_MASK: next_irq_mask = (irq_mask & ~bemask[`RIO_IRQ_W-1:0])
          | (avs_writedata[`RIO_IRQ_W-1:0] & bemask[`RIO_IRQ_W-1:0]);
        // Held until the next power cycle before it acts, see RL6
        `RIO_OFS_CONN: if (avs_byteenable[0]) next_conn_pending = avs_writedata[0];
        default: next_ctrl = ctrl;
      endcase
    end
    // Read clears only bits that were seen; a new event wins
    if (acc_rd && avs_address == `RIO_OFS_IRQ_STAT)
      next_irq_stat = irq_stat & ~avs_readdata[`RIO_IRQ_W-1:0];
    next_irq_stat = next_irq_stat | ev;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl <= `RIO_CTRL_RESET;
      net_in <= 32'h0;
      irq_mask <= '0;
      irq_stat <= '0;
      irq <= 1'b0;
      conn_enable_pending <= 1'b0;
      query <= 32'h0;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      ctrl <= next_ctrl;
      net_in <= next_net_in;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      irq <= next_irq;
      conn_enable_pending <= next_conn_pending;
      query <= next_query;
    end
  end

  // Query checks: busy refuses, wrong link setup is a serial error
  assign q_refused = q_wr && state != RIO_IDLE; // see RL4
  assign q_bad = q_wr && !q_refused && (rxe_s2 || ctrl[`RIO_CTRL_SW]
    || ctrl[`RIO_CTRL_RATE_HI:`RIO_CTRL_RATE_LO] != `RIO_RATE_625K
    || avs_writedata[`RIO_Q_ADDR_HI:`RIO_Q_ADDR_LO]
       != ctrl[`RIO_CTRL_ADDR_HI:`RIO_CTRL_ADDR_LO]); // see RL9
  assign q_ok = q_wr && !q_refused && !q_bad;
  assign gap_end = state == RIO_GAP && cnt == 32'h0;
  assign do_start = gap_end && query[`RIO_Q_KIND_HI:0] == RIO_Q_START;
  assign do_stop = gap_end && query[`RIO_Q_KIND_HI:0] == RIO_Q_STOP;

  // Phase sequencer: wait time, silent gap, processing, config work
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_age = (age == 32'hffff_ffff) ? age : age + 32'h1;
    next_speed = speed;
    next_remote_out = remote_out;
    next_resp = 1'b0;
    next_out_upd = 1'b0;
    next_cfg_done = 1'b0;
    next_err_led = serial_err_led;
    if (q_bad) next_err_led = 1'b1; // see RL10
    if (q_ok) next_err_led = 1'b0;
    case (state)
      RIO_IDLE: if (q_ok) begin
        next_state = RIO_TWAIT;
        next_cnt = 32'(TW_CYC - 1);
        next_age = 32'h0;
      end
      RIO_TWAIT: if (cnt == 32'h0) begin
        next_state = RIO_GAP;
        next_cnt = 32'(GAP_CYC - 1);
      end else next_cnt = cnt - 32'h1;
      RIO_GAP: if (cnt == 32'h0) begin
        next_state = RIO_PROC;
        next_cnt = 32'(PROC_CYC - 1);
        // Outputs move at the end of the gap, well inside the bound, see RL2
        case (query[`RIO_Q_KIND_HI:0])
          RIO_Q_START: begin
            next_speed = query[31:`RIO_Q_DATA_LO];
            next_out_upd = 1'b1;
          end
          RIO_Q_ROUT: begin
            next_remote_out = query[31:`RIO_Q_DATA_LO];
            next_out_upd = 1'b1;
          end
          RIO_Q_SPEED: next_speed = query[31:`RIO_Q_DATA_LO];
          default: next_speed = speed;
        endcase
      end else next_cnt = cnt - 32'h1;
      RIO_PROC: if (cnt == 32'h0) begin
        next_resp = 1'b1; // see RL1
        if (query[`RIO_Q_KIND_HI:0] == RIO_Q_CONFIG) begin
          next_state = RIO_CFG;
          next_cnt = 32'(CFG_CYC - 1);
        end else next_state = RIO_IDLE;
      end else next_cnt = cnt - 32'h1;
      RIO_CFG: if (cnt == 32'h0) begin
        next_state = RIO_IDLE; // see RL3
        next_cfg_done = 1'b1;
      end else next_cnt = cnt - 32'h1;
      default: next_state = RIO_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state <= RIO_IDLE;
      cnt <= 32'h0;
      age <= 32'h0;
      speed <= 16'h0;
      remote_out <= 16'h0;
      resp_pulse <= 1'b0;
      out_upd <= 1'b0;
      cfg_done <= 1'b0;
      cfg_busy <= 1'b0;
      serial_err_led <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      age <= next_age;
      speed <= next_speed;
      remote_out <= next_remote_out;
      resp_pulse <= next_resp;
      out_upd <= next_out_upd;
      cfg_done <= next_cfg_done;
      cfg_busy <= next_state == RIO_CFG;
      serial_err_led <= next_err_led;
    end
  end

  // Continuous run bits count only for axis address 0
  assign cont_fwd = net_in[`RIO_NI_FWD] && ctrl[`RIO_CTRL_ADDR_HI:`RIO_CTRL_ADDR_LO] == 5'h00;
  assign cont_rvs = net_in[`RIO_NI_RVS] && ctrl[`RIO_CTRL_ADDR_HI:`RIO_CTRL_ADDR_LO] == 5'h00;
  assign cont = (cont_fwd ^ cont_rvs) && !net_in[`RIO_NI_STOP] && !net_in[`RIO_NI_FREE];
  assign tick = div == 32'h0;
  assign stopped = motor_decel && tick && dcnt == 16'h0;
  assign ev = {stopped, q_refused, q_bad, cfg_done, out_upd, resp_pulse};

  // Motion: start, ramped or instant stop, continuous run, free
  always_comb begin
    next_run = motor_run;
    next_dir = motor_dir;
    next_decel = motor_decel;
    next_dcnt = dcnt;
    next_div = tick ? 32'(DECEL_DIV - 1) : div - 32'h1;
    next_free = net_in[`RIO_NI_FREE];
    next_cont_prev = cont;
    if (do_start) begin
      next_run = 1'b1;
      next_dir = query[`RIO_Q_DATA_LO];
      next_decel = 1'b0;
    end else if (cont) begin
      next_run = 1'b1; // see RL8
      next_dir = cont_fwd;
      next_decel = 1'b0;
    end else if ((do_stop || (cont_prev && !cont) || net_in[`RIO_NI_STOP]
        || net_in[`RIO_NI_FREE]) && motor_run && !motor_decel) begin
      // Ramp length follows the commanded speed, see RL5
      if (ctrl[`RIO_CTRL_STOPACT] && !net_in[`RIO_NI_FREE]) begin
        next_decel = 1'b1;
        next_dcnt = speed;
      end else next_run = 1'b0;
    end else if (motor_decel && tick) begin
      if (dcnt == 16'h0) begin
        next_run = 1'b0;
        next_decel = 1'b0;
      end else next_dcnt = dcnt - 16'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      motor_run <= 1'b0;
      motor_dir <= 1'b0;
      motor_decel <= 1'b0;
      motor_free <= 1'b0;
      dcnt <= 16'h0;
      div <= 32'h0;
      cont_prev <= 1'b0;
      op_select <= 3'h0;
      direct_select <= 3'h0;
    end else begin
      motor_run <= next_run;
      motor_dir <= next_dir;
      motor_decel <= next_decel;
      motor_free <= next_free;
      dcnt <= next_dcnt;
      div <= next_div;
      cont_prev <= next_cont_prev;
      op_select <= net_in[`RIO_NI_SEL_HI:0]; // see RL7
      direct_select <= net_in[`RIO_NI_DIR_HI:`RIO_NI_DIR_LO];
    end
  end

  // Connection enable is latched once after release; later writes wait
  always_comb begin
    next_boot = boot;
    next_conn_active = conn_enable_active;
    if (boot != 2'h3) next_boot = boot + 2'h1;
    if (boot == 2'h2) next_conn_active = nv_s2; // see RL6
  end

  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      boot <= 2'h0;
      conn_enable_active <= 1'b0;
    end else begin
      boot <= next_boot;
      conn_enable_active <= next_conn_active;
    end
  end

  // Checks on timing and mapping
  AST_RESP_TIME: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL1
    resp_pulse |-> age == 32'(TW_CYC + GAP_CYC + PROC_CYC))
    else $error("response not after wait, gap and processing");
  AST_OUT_TIME: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL2
    out_upd |-> age == 32'(TW_CYC + GAP_CYC) && age <= 32'(TW_CYC + GAP_CYC + OUT_MAX_CYC))
    else $error("output update late");
  AST_CFG_TIME: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL3
    cfg_done |-> age == 32'(TW_CYC + GAP_CYC + PROC_CYC + CFG_CYC)
      && !cfg_busy && $past(cfg_busy) && age <= 32'(TW_CYC + GAP_CYC + PROC_CYC + CFG_MAX_CYC))
    else $error("config processing time wrong");
  AST_BUSY_REFUSE: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL4
    (q_wr && cfg_busy) |=> state != RIO_TWAIT && irq_stat[`RIO_IRQ_REFUSE])
    else $error("query taken during config processing");
  AST_STOP_RAMP: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL5
    (do_stop && motor_run && !motor_decel && !cont && ctrl[`RIO_CTRL_STOPACT]
      && !net_in[`RIO_NI_FREE]) |=> motor_decel && motor_run && dcnt == $past(speed))
    else $error("stop did not ramp");
  AST_CONN_HOLD: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL6
    boot == 2'h3 |=> $stable(conn_enable_active))
    else $error("connection enable changed without power cycle");
  AST_NET_MAP: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL7
    ##1 op_select == $past(net_in[`RIO_NI_SEL_HI:0])
      && direct_select == $past(net_in[`RIO_NI_DIR_HI:`RIO_NI_DIR_LO]))
    else $error("net input mapping wrong");
  AST_CONT_RUN: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL8
    (cont && cont_fwd && !do_start) |=> motor_run && motor_dir)
    else $error("forward continuous run missing");
  AST_LINK_SETUP: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL9
    (q_ok && state == RIO_IDLE) |=> state == RIO_TWAIT
      && $past(ctrl[`RIO_CTRL_RATE_HI:`RIO_CTRL_RATE_LO]) == `RIO_RATE_625K)
    else $error("query accepted with wrong link setup");
  AST_ERR_LED: assert property (@(posedge clock) disable iff (!rst_n_int) // see RL10
    q_bad |=> serial_err_led && irq_stat[`RIO_IRQ_ERR])
    else $error("serial error not indicated");

endmodule // rio_top
`default_nettype wire

// *** tb/rio_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Far-side serial master: error line, stored strap, send permission
module rio_master_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_busy,
  input wire logic resp_pulse,
  input wire logic err_cmd,
  input wire logic strap_cmd,
  output logic rx_error_pin,
  output logic nv_conn_enable,
  output logic may_send,
  output logic [15:0] resp_seen
);
  // Line faults only when the bench asks; rate and address fixed by it
  assign rx_error_pin = err_cmd;
  // Stored enable, read by the device only at power-up
  assign nv_conn_enable = strap_cmd;
  // Hold off queries while configuration work runs
  assign may_send = !cfg_busy;
  // Response counter, a trace of traffic
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resp_seen <= 16'h0000;
    end else if (resp_pulse) begin
      resp_seen <= resp_seen + 16'h0001;
    end
  end
endmodule // rio_master_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rio_params.svh"
module tb;
  localparam int RESP_T = 9;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, rx_error_pin, nv_conn_enable, irq, resp_pulse, may_send;
  logic [15:0] remote_out, resp_seen;
  logic motor_run, motor_dir, motor_decel, motor_free, serial_err_led, cfg_busy;
  logic conn_enable_active, conn_enable_pending;
  logic [2:0] op_select, direct_select;
  logic err_cmd = 1'b0;
  logic strap_cmd = 1'b0;
  logic [23:0] rows [6];
  logic [63:0] bad [3];
  int errors = 0;
  int cmp_count = 0;
  int t;

  rio_top #(.TW_CYC(3), .GAP_CYC(3), .PROC_CYC(3), .CFG_CYC(5), .DECEL_DIV(2)) i_dut (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_error_pin(rx_error_pin), .nv_conn_enable(nv_conn_enable), .irq(irq),
    .resp_pulse(resp_pulse), .remote_out(remote_out), .motor_run(motor_run),
    .motor_dir(motor_dir), .motor_decel(motor_decel), .motor_free(motor_free),
    .op_select(op_select), .direct_select(direct_select),
    .serial_err_led(serial_err_led), .cfg_busy(cfg_busy),
    .conn_enable_active(conn_enable_active), .conn_enable_pending(conn_enable_pending));

  rio_master_model i_master (
    .clock(clock), .reset_n(reset_n), .cfg_busy(cfg_busy), .resp_pulse(resp_pulse),
    .err_cmd(err_cmd), .strap_cmd(strap_cmd), .rx_error_pin(rx_error_pin),
    .nv_conn_enable(nv_conn_enable), .may_send(may_send), .resp_seen(resp_seen));

  // 250 MHz clock
  initial begin
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  // One bus cycle; an extra edge after release keeps strobes from toggling twice
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) errors++;
    @(posedge clock);
  endtask

  // Query write, then cycles from accept to response (30 means none)
  task automatic qry(input logic [31:0] w, output int c);
    while (may_send !== 1'b1) @(posedge clock);
    bus(1'b1, `RIO_OFS_QUERY, w, rd);
    #1;
    c = 1;
    while (resp_pulse !== 1'b1 && c < 30) begin
      @(posedge clock);
      #1;
      c++;
    end
    @(posedge clock);
  endtask

  initial begin
    // Net word, data select, direct select, run, forward
    rows[0] = {16'h4000, 3'h0, 3'h0, 1'b1, 1'b1};
    rows[1] = {16'h0000, 3'h0, 3'h0, 1'b0, 1'b0};
    rows[2] = {16'h8000, 3'h0, 3'h0, 1'b1, 1'b0};
    rows[3] = {16'h4020, 3'h0, 3'h0, 1'b0, 1'b0};
    rows[4] = {16'h0040, 3'h0, 3'h0, 1'b0, 1'b0};
    rows[5] = {16'h0507, 3'h7, 3'h5, 1'b0, 1'b0};
    // Bad settings: control word, query word
    bad[0] = {32'h0000_0030, 32'h0000_0006};
    bad[1] = {32'h0000_0071, 32'h0000_0006};
    bad[2] = {32'h0000_0070, 32'h0000_0016};
    do_reset();
    chk(avs_waitrequest, 1'b1);
    chk(motor_run, 1'b0);
    bus(1'b0, `RIO_OFS_CTRL, 32'h0, rd);
    chk(rd, `RIO_CTRL_RESET);
    bus(1'b0, `RIO_OFS_IRQ_MASK, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, 6'h3c, 32'h0, rd);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, `RIO_OFS_NET_IN, {16'h0, rows[i][23:8]}, rd);
      repeat (3) @(posedge clock);
      chk(op_select, rows[i][7:5]);
      chk(direct_select, rows[i][4:2]);
      chk(motor_run, rows[i][1]);
      if (rows[i][1]) chk(motor_dir, rows[i][0]);
      chk(motor_free, rows[i][14]);
      bus(1'b0, `RIO_OFS_NET_IN, 32'h0, rd);
      chk(rd, {16'h0, rows[i][23:8]});
    end
    // Byte lanes: only lane 1 is written, low byte kept
    avs_byteenable <= 4'h2;
    bus(1'b1, `RIO_OFS_NET_IN, 32'hffff_0000, rd);
    avs_byteenable <= 4'hf;
    bus(1'b0, `RIO_OFS_NET_IN, 32'h0, rd);
    chk(rd, 32'h0000_0007);
    // Start forward at speed 3; masked interrupt stays low
    qry(32'h0003_0001, t);
    chk(t, RESP_T);
    chk(motor_run, 1'b1);
    chk(motor_dir, 1'b1);
    chk(irq, 1'b0);
    bus(1'b0, `RIO_OFS_IRQ_STAT, 32'h0, rd);
    chk(rd & 32'h3, 32'h3);
    // Ramped stop takes speed-dependent time
    bus(1'b1, `RIO_OFS_CTRL, 32'h0001_0070, rd);
    qry(32'h0000_0002, t);
    chk(motor_decel, 1'b1);
    repeat (12) @(posedge clock);
    chk(motor_run, 1'b0);
    bus(1'b0, `RIO_OFS_IRQ_STAT, 32'h0, rd);
    chk(rd & 32'h21, 32'h21);
    // Remote outputs, unmasked interrupt then read-clear
    bus(1'b1, `RIO_OFS_IRQ_MASK, 32'h1, rd);
    qry(32'ha5c3_0004, t);
    @(posedge clock);
    chk(remote_out, 16'ha5c3);
    chk(irq, 1'b1);
    bus(1'b0, `RIO_OFS_IRQ_STAT, 32'h0, rd);
    @(posedge clock);
    chk(irq, 1'b0);
    // Configuration, then a query sent too early on purpose
    qry(32'h0000_0005, t);
    @(posedge clock);
    chk(cfg_busy, 1'b1);
    chk(may_send, 1'b0);
    bus(1'b1, `RIO_OFS_QUERY, 32'h0000_0006, rd);
    repeat (10) @(posedge clock);
    chk(cfg_busy, 1'b0);
    bus(1'b0, `RIO_OFS_IRQ_STAT, 32'h0, rd);
    chk(rd & 32'h15, 32'h15);
    // Line fault, then wrong rate, switch and address
    err_cmd <= 1'b1;
    repeat (4) @(posedge clock);
    qry(32'h0000_0006, t);
    chk(t, 30);
    chk(serial_err_led, 1'b1);
    err_cmd <= 1'b0;
    foreach (bad[i]) begin
      bus(1'b1, `RIO_OFS_CTRL, bad[i][63:32], rd);
      qry(bad[i][31:0], t);
      chk(t, 30);
    end
    qry(32'h0000_0006, t);
    chk(t, RESP_T);
    chk(serial_err_led, 1'b0);
    bus(1'b0, `RIO_OFS_IRQ_STAT, 32'h0, rd);
    chk(rd & 32'h8, 32'h8);
    chk(resp_seen, 16'h0005);
    // Connection enable waits for a power cycle
    bus(1'b1, `RIO_OFS_CONN, 32'h1, rd);
    @(posedge clock);
    chk(conn_enable_pending, 1'b1);
    chk(conn_enable_active, 1'b0);
    strap_cmd <= 1'b1;
    do_reset();
    chk(conn_enable_active, 1'b1);
    chk(conn_enable_pending, 1'b0);
    close_out();
  end

  // Whole run is well under this span
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    close_out();
  end
endmodule // tb
`default_nettype wire
